// file: rtl/swb_ctrl_regs.v
// Serially reached watchdog, bus transceiver and peak threshold control registers
`include "swb_consts.vh"

module swb_ctrl_regs (
   input wire clock,
   input wire rst_b,
   input wire spiClk,
   input wire chipSelectLow,
   input wire spiMosi,
   output wire spiMiso,
   output wire spiMisoOe,
   input wire [1:0] sbcMode,
   input wire softReset,
   input wire failSafeEntry,
   input wire busWake,
   input wire transceiverModeLoad,
   input wire [1:0] firstLinModeIn,
   input wire [1:0] canModeIn,
   input wire intGlobal,
   input wire wakeEvent,
   input wire statusEvent,
   output wire [7:0] watchdogControl,
   output wire [7:0] busTransceiverControl,
   output wire [7:0] peakThresholdControl,
   output wire guardRunEnable,
   output wire windowTypeSelect,
   output wire guardStartLongWindow,
   output wire [9:0] guardPeriodMs,
   output wire guardPeriodValid,
   output wire slopeControlOff,
   output wire lowSlopeSelect,
   output wire transmitTimeoutEnable,
   output wire [1:0] firstLinMode,
   output wire [1:0] canMode,
   output wire peakCurrentThreshold,
   output wire thirdRailVoltageCfg,
   output wire thirdRailLoadShare,
   output wire externalWakeForce,
   output wire checksumError,
   output wire interruptRequest
);
   // ****************************************************************
   // Link input sampling
   // ****************************************************************
   wire [2:0] syncPins;
   wire sclkS;
   wire csS;
   wire mosiS;
   reg sclkPrev_ff;
   reg csPrev_ff;

   swb_sync #(
      .WIDTH(3)
   ) uSync (
      .clock(clock),
      .rst_b(rst_b),
      .asyncIn({spiClk, chipSelectLow, spiMosi}),
      .syncOut(syncPins)
   );

   assign sclkS = syncPins[2];
   assign csS = syncPins[1];
   assign mosiS = syncPins[0];

   wire sclkRise = sclkS & ~sclkPrev_ff & ~csS;
   wire sclkFall = ~sclkS & sclkPrev_ff & ~csS;
   wire csFall = ~csS & csPrev_ff;
   wire csRise = csS & ~csPrev_ff;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [7:0] wd_ff;
   reg [7:0] bus1_ff;
   reg [7:0] bus2_ff;
   reg vCfg_ff;
   reg loadShare_ff;
   reg [15:0] shiftIn_ff;
   reg [4:0] bitCnt_ff;
   reg overrun_ff;
   reg [7:0] readSnap_ff;
   reg miso_ff;
   reg misoOe_ff;
   reg runEn_ff;
   reg startLong_ff;
   reg [9:0] periodMs_ff;
   reg periodValid_ff;
   reg extForce_ff;
   reg csumErr_ff;
   reg irq_ff;

   reg [7:0] nxt_readSnap;
   reg [9:0] nxt_periodMs;

   wire [6:0] frameAddr = shiftIn_ff[6:0];
   wire frameWrite = shiftIn_ff[7];
   wire [7:0] frameData = shiftIn_ff[15:8];
   wire frameDone = csRise && (bitCnt_ff == `SWB_FRAME_BITS) && !overrun_ff && frameWrite;
   wire stopMode = (sbcMode == `SWB_MODE_STOP);
   wire dataParityOk = ~^frameData;

   // Address is complete before the eighth edge shifts in
   always @* begin
      case (shiftIn_ff[15:9])
         `SWB_ADDR_HW: nxt_readSnap = {vCfg_ff, 3'h0, loadShare_ff, 3'h0};
         `SWB_ADDR_WD: nxt_readSnap = wd_ff;
         `SWB_ADDR_BUS1: nxt_readSnap = bus1_ff;
         `SWB_ADDR_BUS2: nxt_readSnap = bus2_ff;
         default: nxt_readSnap = 8'h00;
      endcase
   end

   // ****************************************************************
   // Serial frame engine
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_b) begin
         sclkPrev_ff <= 1'b0;
         csPrev_ff <= 1'b1;
         shiftIn_ff <= 16'h0000;
         bitCnt_ff <= 5'h00;
         overrun_ff <= 1'b0;
         readSnap_ff <= 8'h00;
         miso_ff <= 1'b0;
         misoOe_ff <= 1'b0;
      end else begin
         sclkPrev_ff <= sclkS;
         csPrev_ff <= csS;
         misoOe_ff <= ~csS;
         if (csFall) begin
            bitCnt_ff <= 5'h00;
            overrun_ff <= 1'b0;
            miso_ff <= 1'b0;
         end else if (sclkRise && bitCnt_ff != `SWB_FRAME_BITS) begin
            // Least significant bit first
            shiftIn_ff <= {mosiS, shiftIn_ff[15:1]};
            bitCnt_ff <= bitCnt_ff + 5'h01;
            if (bitCnt_ff == `SWB_DATA_START - 5'h01) begin
               readSnap_ff <= nxt_readSnap;
            end
         end else if (sclkRise) begin
            // A seventeenth edge spoils the frame
            overrun_ff <= 1'b1;
         end else if (sclkFall) begin
            // First byte carries no status here; second byte the register
            if (bitCnt_ff >= `SWB_DATA_START && bitCnt_ff != `SWB_FRAME_BITS) begin
               miso_ff <= readSnap_ff[bitCnt_ff[2:0]];
            end else begin
               miso_ff <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   wire writeWd = frameDone && (frameAddr == `SWB_ADDR_WD);
   wire writeBus1 = frameDone && (frameAddr == `SWB_ADDR_BUS1);
   wire writeBus2 = frameDone && (frameAddr == `SWB_ADDR_BUS2);
   wire writeHw = frameDone && (frameAddr == `SWB_ADDR_HW);

   // ****************************************************************
   // Watchdog control
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_b) begin
         wd_ff <= `SWB_RST_WD;
      end else if (softReset) begin
         wd_ff <= `SWB_RST_WD;
      end else if (writeWd && dataParityOk) begin
         // Odd parity keeps the old setting
         wd_ff <= frameData & `SWB_MASK_WD;
      end
   end

   // ****************************************************************
   // Checksum flag
   // ****************************************************************
   // Follows the latest watchdog write; soft reset drops that write too
   always @(posedge clock) begin
      if (!rst_b) begin
         csumErr_ff <= 1'b0;
      end else if (softReset) begin
         csumErr_ff <= 1'b0;
      end else if (writeWd) begin
         csumErr_ff <= ~dataParityOk;
      end
   end

   // ****************************************************************
   // Bus transceiver control
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_b) begin
         bus1_ff <= `SWB_RST_BUS1;
      end else if (softReset) begin
         bus1_ff <= `SWB_RST_BUS1;
      end else if (failSafeEntry) begin
         // Fail-safe and cause-driven loads override a same-cycle write
         bus1_ff <= {bus1_ff[7:5], `SWB_FAILSAFE_BUS_LOW};
      end else if (transceiverModeLoad) begin
         bus1_ff <= {bus1_ff[7:5], firstLinModeIn, 1'b0, canModeIn};
      end else if (writeBus1) begin
         // Takes effect at select release, one copy for both LINs
         bus1_ff <= frameData & `SWB_MASK_BUS1;
      end
   end

   // ****************************************************************
   // Peak threshold control
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_b) begin
         bus2_ff <= `SWB_RST_BUS2;
      end else if (softReset) begin
         bus2_ff <= `SWB_RST_BUS2;
      end else if (writeBus2 && !stopMode) begin
         // Silently dropped in Stop, no failure flag raised
         bus2_ff <= frameData & `SWB_MASK_BUS2;
      end
   end

   // ****************************************************************
   // Third rail bits and fail-safe pulse
   // ****************************************************************
   // Only power-on clears these; soft reset leaves them as they are
   always @(posedge clock) begin
      if (!rst_b) begin
         vCfg_ff <= 1'b0;
         loadShare_ff <= 1'b0;
      end else if (writeHw && !softReset) begin
         vCfg_ff <= frameData[`SWB_HW_V_CFG];
         loadShare_ff <= frameData[`SWB_HW_LOAD_SHARE];
      end
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         extForce_ff <= 1'b0;
      end else begin
         extForce_ff <= failSafeEntry;
      end
   end

   // ****************************************************************
   // Watchdog and interrupt outputs
   // ****************************************************************
   always @* begin
      case (wd_ff[2:0])
         3'h0: nxt_periodMs = `SWB_PERIOD_0;
         3'h1: nxt_periodMs = `SWB_PERIOD_1;
         3'h2: nxt_periodMs = `SWB_PERIOD_2;
         3'h3: nxt_periodMs = `SWB_PERIOD_3;
         3'h4: nxt_periodMs = `SWB_PERIOD_4;
         3'h5: nxt_periodMs = `SWB_PERIOD_5;
         3'h6: nxt_periodMs = `SWB_PERIOD_6;
         default: nxt_periodMs = 10'h000;
      endcase
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         runEn_ff <= 1'b1;
         startLong_ff <= 1'b0;
         periodMs_ff <= `SWB_PERIOD_0;
         periodValid_ff <= 1'b1;
         irq_ff <= 1'b0;
      end else begin
         runEn_ff <= ~(stopMode & wd_ff[`SWB_WD_STOP_OFF]);
         startLong_ff <= busWake & stopMode & wd_ff[`SWB_WD_BUS_WAKE];
         periodMs_ff <= nxt_periodMs;
         periodValid_ff <= (wd_ff[2:0] != 3'h7);
         irq_ff <= wakeEvent | (intGlobal & statusEvent);
      end
   end

   // ****************************************************************
   // Output ports
   // ****************************************************************
   assign spiMiso = miso_ff;
   assign spiMisoOe = misoOe_ff;
   assign watchdogControl = wd_ff;
   assign busTransceiverControl = bus1_ff;
   assign peakThresholdControl = bus2_ff;
   assign guardRunEnable = runEn_ff;
   assign windowTypeSelect = wd_ff[`SWB_WD_WINDOW];
   assign guardStartLongWindow = startLong_ff;
   assign guardPeriodMs = periodMs_ff;
   assign guardPeriodValid = periodValid_ff;
   assign slopeControlOff = bus1_ff[`SWB_BUS_FLASH];
   assign lowSlopeSelect = bus1_ff[`SWB_BUS_LOW_SLOPE];
   assign transmitTimeoutEnable = bus1_ff[`SWB_BUS_TXD_TO];
   assign firstLinMode = bus1_ff[4:3];
   assign canMode = bus1_ff[1:0];
   assign peakCurrentThreshold = bus2_ff[`SWB_BUS2_PEAK];
   assign thirdRailVoltageCfg = vCfg_ff;
   assign thirdRailLoadShare = loadShare_ff;
   assign externalWakeForce = extForce_ff;
   assign checksumError = csumErr_ff;
   assign interruptRequest = irq_ff;
endmodule

// file: rtl/swb_consts.vh
// Register map, field positions, reset values and link constants of the watchdog and bus registers
// Functional notes
// - Bit 6 stops watchdog in Stop Mode
// - Bit 5: time-out or window watchdog
// - Bit 4: bus wake starts watchdog
// - Period codes 0..6 map to 10..1000 ms, code 7 is invalid
// - Reserved bits read as zero
// - Flash bit disables LIN slope control
// - Bit 6 selects LIN low-slope mode
// - Bit 5 enables LIN transmit time-out
// - Bits 4:3 select first LIN mode
// - Bits 1:0 select CAN mode
// - LIN options apply at select release, both
// - Fail-safe forces wake-capable bus settings
// - Bit 5 selects peak current threshold
// - Threshold write ignored silently in Stop
// - Soft reset keeps third rail bits
// - Transceiver mode reset depends on cause
// - Global bit lets all status interrupt
`ifndef SWB_CONSTS_VH
`define SWB_CONSTS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SWB_ADDR_HW 7'h02
`define SWB_ADDR_WD 7'h03
`define SWB_ADDR_BUS1 7'h04
`define SWB_ADDR_BUS2 7'h05

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define SWB_RST_WD 8'h14
`define SWB_RST_BUS1 8'h20
`define SWB_RST_BUS2 8'h00
`define SWB_MASK_WD 8'hF7
`define SWB_MASK_BUS1 8'hFB
`define SWB_MASK_BUS2 8'h20
`define SWB_MASK_HW 8'h88

// ****************************************************************
// Field positions
// ****************************************************************
`define SWB_WD_STOP_OFF 6
`define SWB_WD_WINDOW 5
`define SWB_WD_BUS_WAKE 4
`define SWB_BUS_FLASH 7
`define SWB_BUS_LOW_SLOPE 6
`define SWB_BUS_TXD_TO 5
`define SWB_BUS2_PEAK 5
`define SWB_HW_V_CFG 7
`define SWB_HW_LOAD_SHARE 3

// Low five bits forced on fail-safe entry: FIRST_LIN_MODE and CAN wake capable
`define SWB_FAILSAFE_BUS_LOW 5'h09

// ****************************************************************
// Modes and watchdog periods
// ****************************************************************
`define SWB_MODE_INIT 2'h0
`define SWB_MODE_NORMAL 2'h1
`define SWB_MODE_STOP 2'h2
`define SWB_PERIOD_0 10'h00A
`define SWB_PERIOD_1 10'h014
`define SWB_PERIOD_2 10'h032
`define SWB_PERIOD_3 10'h064
`define SWB_PERIOD_4 10'h0C8
`define SWB_PERIOD_5 10'h1F4
`define SWB_PERIOD_6 10'h3E8

// Frame length in serial clock edges
`define SWB_FRAME_BITS 5'h10
`define SWB_DATA_START 5'h08

`endif

// file: rtl/swb_sync.v
// Two-stage synchroniser for asynchronous serial-link inputs
module swb_sync #(
   parameter WIDTH = 3
) (
   input wire clock,
   input wire rst_b,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_ff;
   reg [WIDTH-1:0] stage2_ff;
   genvar i;

   // First stage feeds only the second stage
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : gSync
         always @(posedge clock) begin
            if (!rst_b) begin
               stage1_ff[i] <= 1'b1;
               stage2_ff[i] <= 1'b1;
            end else begin
               stage1_ff[i] <= asyncIn[i];
               stage2_ff[i] <= stage1_ff[i];
            end
         end
      end
   endgenerate

   assign syncOut = stage2_ff;
endmodule

// file: tb/swb_ctrl_regs_asserts.sv
// Port assertions for the watchdog and bus control registers
`include "swb_consts.vh"
module swb_ctrl_regs_asserts (
   input wire clock,
   input wire rst_b,
   input wire chipSelectLow,
   input wire [1:0] sbcMode,
   input wire softReset,
   input wire failSafeEntry,
   input wire busWake,
   input wire [7:0] watchdogControl,
   input wire [7:0] busTransceiverControl,
   input wire [7:0] peakThresholdControl,
   input wire guardRunEnable,
   input wire guardStartLongWindow,
   input wire guardPeriodValid,
   input wire slopeControlOff,
   input wire lowSlopeSelect,
   input wire transmitTimeoutEnable,
   input wire peakCurrentThreshold,
   input wire externalWakeForce
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire stopMode = (sbcMode == `SWB_MODE_STOP);
   a_reserved_zero: assert property (
      !watchdogControl[3] && !busTransceiverControl[2] && !(|(peakThresholdControl & 8'hDF)))
      else $error("reserved bit set");
   a_stop_guard_off: assert property (
      guardRunEnable == !($past(stopMode) && $past(watchdogControl[6])))
      else $error("guard run enable wrong");
   a_long_window: assert property (
      guardStartLongWindow == $past(busWake && stopMode && watchdogControl[4]))
      else $error("long window start wrong");
   a_period_valid: assert property (
      guardPeriodValid == ($past(watchdogControl[2:0]) != 3'h7))
      else $error("period valid wrong");
   a_lin_options: assert property (
      {slopeControlOff, lowSlopeSelect, transmitTimeoutEnable} == busTransceiverControl[7:5])
      else $error("lin option outputs wrong");
   a_lin_on_release: assert property (
      $changed(busTransceiverControl[7:5]) |-> chipSelectLow || $past(softReset))
      else $error("lin options changed inside a frame");
   a_fail_safe_force: assert property (
      failSafeEntry && !softReset |=> busTransceiverControl[4:0] == 5'h09 && externalWakeForce)
      else $error("fail-safe force missing");
   a_peak_stop_hold: assert property (
      stopMode && !softReset |=> $stable(peakThresholdControl))
      else $error("threshold changed in stop");
   a_soft_reload: assert property (
      softReset |=> watchdogControl == 8'h14 && busTransceiverControl == 8'h20
         && peakThresholdControl == 8'h00)
      else $error("soft reset values wrong");
   a_peak_bit: assert property (
      peakCurrentThreshold == peakThresholdControl[5])
      else $error("threshold output wrong");
endmodule

bind swb_ctrl_regs swb_ctrl_regs_asserts chk (.*);

// file: tb/swb_spi_host.sv
// Serial host model driving sixteen-bit frames into the register block
module swb_spi_host (
   input wire clock,
   input wire spiMiso,
   output logic spiClk,
   output logic chipSelectLow,
   output logic spiMosi,
   output logic gotData,
   output logic [7:0] rxData
);
   timeunit 1ns;
   timeprecision 1ps;
   // Select released, link clock idle low
   initial {spiClk, chipSelectLow, spiMosi, gotData, rxData} = 12'h400;
   task automatic frame(input [6:0] addr, input wr, input [7:0] dat);
      logic [15:0] f;
      f = {dat, wr, addr};
      @(negedge clock) chipSelectLow = 0;
      for (int i = 0; i < 16; i++) begin
         spiMosi = f[i];
         repeat (4) @(negedge clock);
         spiClk = 1;
         repeat (4) @(negedge clock);
         // Late in the high half: reply has had time through the syncs
         if (i > 7) rxData[i-8] = spiMiso;
         spiClk = 0;
      end
      repeat (4) @(negedge clock);
      chipSelectLow = 1;
      // Released line has no pull, so never leave the last bit showing
      spiMosi = ~spiMosi;
      gotData = !wr;
      @(negedge clock) gotData = 0;
      repeat (8) @(negedge clock);
   endtask
endmodule

// file: tb/test_swb_ctrl_regs.sv
// Self-checking bench for the watchdog and bus control registers
`include "swb_consts.vh"
`define CHK(nm, e, a) begin compares++; if ((e) !== (a)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module test_swb_ctrl_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_b, softReset, failSafeEntry, busWake, transceiverModeLoad;
   logic intGlobal, wakeEvent, statusEvent;
   logic [1:0] sbcMode, firstLinModeIn, canModeIn;
   logic [7:0] d, expNow;
   logic [7:0] expQ[$];
   logic [9:0] per[8] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h3E8, 10'h000};
   int miscompares, compares, seed;
   wire spiClk, chipSelectLow, spiMosi, spiMiso, gotData, guardRunEnable, windowTypeSelect;
   wire guardStartLongWindow, guardPeriodValid, slopeControlOff, lowSlopeSelect;
   wire transmitTimeoutEnable, peakCurrentThreshold, thirdRailVoltageCfg, thirdRailLoadShare;
   wire externalWakeForce, checksumError, interruptRequest, spiMisoOe;
   wire [1:0] firstLinMode, canMode;
   wire [7:0] rxData, watchdogControl, busTransceiverControl, peakThresholdControl;
   wire [9:0] guardPeriodMs;
   swb_ctrl_regs uut (.*);
   swb_spi_host host (.*);
   task automatic rd(input [6:0] a, input [7:0] e);
      expQ.push_back(e);
      host.frame(a, 1'b0, 8'h00);
   endtask
   task automatic wr(input [6:0] a, input [7:0] v);
      host.frame(a, 1'b1, v);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clock) s = 1;
      @(negedge clock) s = 0;
   endtask
   task automatic give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) if (gotData) begin
      expNow = expQ.pop_front();
      `CHK("readback", expNow, rxData)
      `CHK("misoOe", 1'b1, spiMisoOe)
   end
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   initial begin
      #300us;
      miscompares++;
      give_verdict();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {softReset, failSafeEntry, busWake, transceiverModeLoad} = 4'h0;
      {intGlobal, wakeEvent, statusEvent, rst_b} = 4'h0;
      {sbcMode, firstLinModeIn, canModeIn} = 6'h10;
      seed = $urandom(32'h0000_bdf3);
      repeat (10) @(negedge clock);
      rst_b = 1;
      repeat (4) @(negedge clock);
      rd(`SWB_ADDR_WD, 8'h14);
      rd(`SWB_ADDR_BUS1, 8'h20);
      rd(`SWB_ADDR_BUS2, 8'h00);
      rd(7'h40, 8'h00);
      `CHK("misoIdle", 1'b0, spiMisoOe)
      $display("reset test done");
      for (int c = 0; c < 8; c++) begin
         d = {1'b0, 3'($urandom), 1'b0, 3'(c)};
         d[7] = ^d;
         wr(`SWB_ADDR_WD, d);
         rd(`SWB_ADDR_WD, d);
         `CHK("period", per[c], guardPeriodMs)
         `CHK("valid", c != 7, guardPeriodValid)
         `CHK("window", d[5], windowTypeSelect)
      end
      wr(`SWB_ADDR_WD, 8'h01);
      `CHK("parity", 1'b1, checksumError)
      rd(`SWB_ADDR_WD, d);
      wr(`SWB_ADDR_WD, 8'h9C);
      rd(`SWB_ADDR_WD, 8'h94);
      $display("watchdog test done");
      repeat (4) begin
         d = 8'($urandom);
         wr(`SWB_ADDR_BUS1, d);
         rd(`SWB_ADDR_BUS1, d & 8'hFB);
         `CHK("opts", d[7:5], {slopeControlOff, lowSlopeSelect, transmitTimeoutEnable})
         `CHK("modes", {d[4:3], d[1:0]}, {firstLinMode, canMode})
      end
      wr(`SWB_ADDR_BUS2, 8'hFF);
      rd(`SWB_ADDR_BUS2, 8'h20);
      sbcMode = `SWB_MODE_STOP;
      wr(`SWB_ADDR_BUS2, 8'h00);
      rd(`SWB_ADDR_BUS2, 8'h20);
      wr(`SWB_ADDR_WD, 8'hD4);
      `CHK("guardRun", 1'b0, guardRunEnable)
      pulse(busWake);
      `CHK("longWin", 1'b1, guardStartLongWindow)
      sbcMode = `SWB_MODE_NORMAL;
      $display("bus test done");
      {firstLinModeIn, canModeIn} = 4'hB;
      pulse(transceiverModeLoad);
      `CHK("modeLoad", 4'hB, {firstLinMode, canMode})
      pulse(failSafeEntry);
      `CHK("wakeForce", 1'b1, externalWakeForce)
      `CHK("failSafe", 5'h09, busTransceiverControl[4:0])
      wr(`SWB_ADDR_HW, 8'hFF);
      pulse(softReset);
      `CHK("rail", 2'h3, {thirdRailVoltageCfg, thirdRailLoadShare})
      rd(`SWB_ADDR_WD, 8'h14);
      rst_b = 0;
      repeat (10) @(negedge clock);
      rst_b = 1;
      repeat (4) @(negedge clock);
      `CHK("railPor", 2'h0, {thirdRailVoltageCfg, thirdRailLoadShare})
      for (int g = 0; g < 2; g++) begin
         intGlobal = g[0];
         pulse(statusEvent);
         `CHK("irq", g[0], interruptRequest)
      end
      intGlobal = 0;
      pulse(wakeEvent);
      `CHK("wakeIrq", 1'b1, interruptRequest)
      $display("event test done");
      give_verdict();
   end
endmodule
